// *** hdl/dpt_pkg.sv ***
// package: register map, field layout and reset values of the dual pwm block
package dpt_pkg;
    // ========================================================
    // register bus geometry, timer and duty widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int TMR_W = 8;
    localparam int SUB_W = 2;
    localparam int DUTY_W = 10;

    // ========================================================
    // register offsets
    localparam logic [2:0] OFS_A_CONTROL = 3'h0;
    localparam logic [2:0] OFS_A_DUTY_HIGH = 3'h1;
    localparam logic [2:0] OFS_A_DUTY_LOW = 3'h2;
    localparam logic [2:0] OFS_B_CONTROL = 3'h3;
    localparam logic [2:0] OFS_B_DUTY_HIGH = 3'h4;
    localparam logic [2:0] OFS_B_DUTY_LOW = 3'h5;
    localparam logic [2:0] OFS_TIMER_SOURCE_SELECT = 3'h6;

    // ========================================================
    // field positions
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_LEVEL_BIT = 5;
    localparam int CTRL_INVERT_BIT = 4;
    localparam int DUTY_LOW_HI_BIT = 7;
    localparam int DUTY_LOW_LO_BIT = 6;
    localparam int PICK_B_HI_BIT = 3;
    localparam int PICK_B_LO_BIT = 2;
    localparam int PICK_A_HI_BIT = 1;
    localparam int PICK_A_LO_BIT = 0;

    // ========================================================
    // reset values and constants
    localparam logic [7:0] DUTY_HIGH_RESET = 8'h00;
    localparam logic [1:0] DUTY_LOW_RESET = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [9:0] DUTY_ZERO = 10'h000;

    // timer pick codes, 00 is reserved and selects no timer
    typedef enum logic [1:0] {
        PICK_NONE = 2'b00,
        PICK_T2 = 2'b01,
        PICK_T4 = 2'b10,
        PICK_T6 = 2'b11
    } dpt_pick_type;

    localparam dpt_pick_type PICK_RESET = PICK_T2;
endpackage : dpt_pkg

// *** hdl/dpt_channel.sv ***
// one pwm channel: timer selection, duty buffer, compare and pin drive
`timescale 1ns/1ps
`default_nettype none
module dpt_channel #(
    parameter int TMR_W = 8,
    parameter int DUTY_W = 10
) (
    input wire logic mclk_i,                 // system clock
    input wire logic rst_i,                  // sync reset, active high
    input wire logic enable_i,               // channel enable
    input wire logic invert_i,               // active-low output when set
    input wire dpt_pkg::dpt_pick_type pick_i, // timer pick code
    input wire logic [DUTY_W-1:0] duty_i,    // buffered duty value
    input wire logic [DUTY_W-1:0] tb2_i,     // time base of timer two
    input wire logic rl2_i,                  // timer two reload pulse
    input wire logic [DUTY_W-1:0] tb4_i,     // time base of timer four
    input wire logic rl4_i,                  // timer four reload pulse
    input wire logic [DUTY_W-1:0] tb6_i,     // time base of timer six
    input wire logic rl6_i,                  // timer six reload pulse
    output logic pin_o                       // pin level after polarity
);
    // ========================================================
    // elaboration check
    if (DUTY_W != TMR_W + dpt_pkg::SUB_W) begin : g_bad_width
        $error("duty width must be timer width plus two");
    end

    logic [DUTY_W-1:0] tb_sel;
    logic rl_sel;
    logic [DUTY_W-1:0] duty_reg;
    logic raw_reg;
    logic raw_next;
    logic pin_reg;

    // ========================================================
    // timer routing; reserved code leaves the channel frozen
    always_comb begin
        unique case (pick_i)
            dpt_pkg::PICK_T2: begin
                tb_sel = tb2_i;
                rl_sel = rl2_i;
            end
            dpt_pkg::PICK_T4: begin
                tb_sel = tb4_i;
                rl_sel = rl4_i;
            end
            dpt_pkg::PICK_T6: begin
                tb_sel = tb6_i;
                rl_sel = rl6_i;
            end
            dpt_pkg::PICK_NONE: begin
                tb_sel = dpt_pkg::DUTY_ZERO;
                rl_sel = 1'b0;
            end
        endcase
    end

    // duty latched only at the period rollover, keeps pulses glitch free
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            duty_reg <= dpt_pkg::DUTY_ZERO;
        end else if (rl_sel) begin
            duty_reg <= duty_i;
        end
    end

    // set at rollover unless zero duty, clear when time base hits duty
    always_comb begin
        raw_next = raw_reg;
        if (rl_sel) begin
            raw_next = (duty_i != dpt_pkg::DUTY_ZERO);
        end else if (tb_sel == duty_reg) begin
            raw_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            raw_reg <= 1'b0;
        end else begin
            raw_reg <= raw_next;
        end
    end

    // disabled channel sits at the polarity default level
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= enable_i ? (raw_next ^ invert_i) : invert_i;
        end
    end

    assign pin_o = pin_reg;

    // ========================================================
    // assertions
    sequence s_rollover_nonzero;
        rl_sel && (duty_i != dpt_pkg::DUTY_ZERO);
    endsequence

    sequence s_rollover_zero;
        rl_sel && (duty_i == dpt_pkg::DUTY_ZERO);
    endsequence

    AST_ROLLOVER_SETS: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_rollover_nonzero ##1 !rst_i
        |-> raw_reg && (duty_reg == $past(duty_i)))
        else $error("rollover with duty did not set output");

    AST_ZERO_DUTY_LOW: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_rollover_zero |=> !raw_reg)
        else $error("zero duty set the output");

    AST_DUTY_HELD: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rl_sel |=> $stable(duty_reg))
        else $error("duty changed outside rollover");

    AST_MATCH_CLEARS: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rl_sel && (tb_sel == duty_reg) |=> !raw_reg)
        else $error("compare match did not clear output");

    AST_DISABLED_DEFAULT: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !enable_i |=> pin_o == $past(invert_i))
        else $error("disabled channel not at default level");

    AST_POLARITY: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        enable_i ##1 !rst_i |-> pin_o == (raw_reg ^ $past(invert_i)))
        else $error("enabled pin does not follow polarity");
endmodule : dpt_channel
`default_nettype wire

// *** hdl/dpt_dual_pwm.sv ***
// top: register file and two pwm channels sharing three period timers
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dpt_dual_pwm #(
    parameter int TMR_W = dpt_pkg::TMR_W,
    parameter int DUTY_W = dpt_pkg::DUTY_W
) (
    input wire logic mclk_i,                          // system clock
    input wire logic rst_i,                           // sync reset
    input wire logic [dpt_pkg::ADDR_W-1:0] addr_i,    // register address
    input wire logic [dpt_pkg::DATA_W-1:0] wdata_i,   // write data
    input wire logic wr_i,                            // write strobe
    input wire logic rd_i,                            // read strobe
    output logic [dpt_pkg::DATA_W-1:0] rdata_o,       // read data, next cycle
    input wire logic [DUTY_W-1:0] period_timer_two_base_i,        // timer two time base
    input wire logic period_timer_two_reload_i,                   // timer two rollover
    input wire logic [DUTY_W-1:0] period_timer_four_base_i,        // timer four time base
    input wire logic period_timer_four_reload_i,                   // timer four rollover
    input wire logic [DUTY_W-1:0] period_timer_six_base_i,        // timer six time base
    input wire logic period_timer_six_reload_i,                   // timer six rollover
    output logic chan_a_pin_o,                        // channel a pin
    output logic chan_b_pin_o                         // channel b pin
);
    // ========================================================
    // elaboration check
    if (DUTY_W != dpt_pkg::DUTY_W || TMR_W != dpt_pkg::TMR_W) begin : g_bad
        $error("register layout serves only a ten-bit duty");
    end

    logic chan_a_enable_reg;
    logic chan_a_invert_reg;
    logic [7:0] chan_a_duty_high_reg;
    logic [1:0] chan_a_duty_low_reg;
    logic chan_b_enable_reg;
    logic chan_b_invert_reg;
    logic [7:0] chan_b_duty_high_reg;
    logic [1:0] chan_b_duty_low_reg;
    dpt_pkg::dpt_pick_type chan_a_timer_pick_reg;
    dpt_pkg::dpt_pick_type chan_b_timer_pick_reg;
    logic [dpt_pkg::DATA_W-1:0] rdata_reg;
    logic [dpt_pkg::DATA_W-1:0] rdata_next;
    logic [DUTY_W-1:0] chan_a_duty_value;
    logic [DUTY_W-1:0] chan_b_duty_value;
    logic chan_a_pin;
    logic chan_b_pin;

    // ========================================================
    // control registers of both channels
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chan_a_enable_reg <= 1'b0;
            chan_a_invert_reg <= 1'b0;
            chan_b_enable_reg <= 1'b0;
            chan_b_invert_reg <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == dpt_pkg::OFS_A_CONTROL) begin
                chan_a_enable_reg <= wdata_i[dpt_pkg::CTRL_ENABLE_BIT];
                chan_a_invert_reg <= wdata_i[dpt_pkg::CTRL_INVERT_BIT];
            end
            if (addr_i == dpt_pkg::OFS_B_CONTROL) begin
                chan_b_enable_reg <= wdata_i[dpt_pkg::CTRL_ENABLE_BIT];
                chan_b_invert_reg <= wdata_i[dpt_pkg::CTRL_INVERT_BIT];
            end
        end
    end

    // duty registers; only bits 7:6 of the low register are stored
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chan_a_duty_high_reg <= dpt_pkg::DUTY_HIGH_RESET;
            chan_a_duty_low_reg <= dpt_pkg::DUTY_LOW_RESET;
            chan_b_duty_high_reg <= dpt_pkg::DUTY_HIGH_RESET;
            chan_b_duty_low_reg <= dpt_pkg::DUTY_LOW_RESET;
        end else if (wr_i) begin
            if (addr_i == dpt_pkg::OFS_A_DUTY_HIGH) begin
                chan_a_duty_high_reg <= wdata_i;
            end
            if (addr_i == dpt_pkg::OFS_A_DUTY_LOW) begin
                chan_a_duty_low_reg <= wdata_i[dpt_pkg::DUTY_LOW_HI_BIT:
                                               dpt_pkg::DUTY_LOW_LO_BIT];
            end
            if (addr_i == dpt_pkg::OFS_B_DUTY_HIGH) begin
                chan_b_duty_high_reg <= wdata_i;
            end
            if (addr_i == dpt_pkg::OFS_B_DUTY_LOW) begin
                chan_b_duty_low_reg <= wdata_i[dpt_pkg::DUTY_LOW_HI_BIT:
                                               dpt_pkg::DUTY_LOW_LO_BIT];
            end
        end
    end

    // timer pick fields; upper nibble has no storage at all
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chan_a_timer_pick_reg <= dpt_pkg::PICK_RESET;
            chan_b_timer_pick_reg <= dpt_pkg::PICK_RESET;
        end else if (wr_i && addr_i == dpt_pkg::OFS_TIMER_SOURCE_SELECT) begin
            chan_b_timer_pick_reg <= dpt_pkg::dpt_pick_type'(
                wdata_i[dpt_pkg::PICK_B_HI_BIT:dpt_pkg::PICK_B_LO_BIT]);
            chan_a_timer_pick_reg <= dpt_pkg::dpt_pick_type'(
                wdata_i[dpt_pkg::PICK_A_HI_BIT:dpt_pkg::PICK_A_LO_BIT]);
        end
    end

    // ========================================================
    // duty value is left justified: high byte on top, two bits below
    assign chan_a_duty_value =
        {chan_a_duty_high_reg, chan_a_duty_low_reg};
    assign chan_b_duty_value =
        {chan_b_duty_high_reg, chan_b_duty_low_reg};

    // ========================================================
    // read mux; every unused position and unmapped address reads zero
    always_comb begin
        rdata_next = dpt_pkg::READ_ZERO;
        unique case (addr_i)
            dpt_pkg::OFS_A_CONTROL: begin
                rdata_next[dpt_pkg::CTRL_ENABLE_BIT] = chan_a_enable_reg;
                rdata_next[dpt_pkg::CTRL_LEVEL_BIT] = chan_a_pin;
                rdata_next[dpt_pkg::CTRL_INVERT_BIT] = chan_a_invert_reg;
            end
            dpt_pkg::OFS_A_DUTY_HIGH: begin
                rdata_next = chan_a_duty_high_reg;
            end
            dpt_pkg::OFS_A_DUTY_LOW: begin
                rdata_next[dpt_pkg::DUTY_LOW_HI_BIT:dpt_pkg::DUTY_LOW_LO_BIT] =
                    chan_a_duty_low_reg;
            end
            dpt_pkg::OFS_B_CONTROL: begin
                rdata_next[dpt_pkg::CTRL_ENABLE_BIT] = chan_b_enable_reg;
                rdata_next[dpt_pkg::CTRL_LEVEL_BIT] = chan_b_pin;
                rdata_next[dpt_pkg::CTRL_INVERT_BIT] = chan_b_invert_reg;
            end
            dpt_pkg::OFS_B_DUTY_HIGH: begin
                rdata_next = chan_b_duty_high_reg;
            end
            dpt_pkg::OFS_B_DUTY_LOW: begin
                rdata_next[dpt_pkg::DUTY_LOW_HI_BIT:dpt_pkg::DUTY_LOW_LO_BIT] =
                    chan_b_duty_low_reg;
            end
            dpt_pkg::OFS_TIMER_SOURCE_SELECT: begin
                rdata_next[dpt_pkg::PICK_B_HI_BIT:dpt_pkg::PICK_B_LO_BIT] =
                    chan_b_timer_pick_reg;
                rdata_next[dpt_pkg::PICK_A_HI_BIT:dpt_pkg::PICK_A_LO_BIT] =
                    chan_a_timer_pick_reg;
            end
            default: begin
                rdata_next = dpt_pkg::READ_ZERO;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_reg <= dpt_pkg::READ_ZERO;
        end else if (rd_i) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= dpt_pkg::READ_ZERO;
        end
    end

    assign rdata_o = rdata_reg;

    // ========================================================
    // channels; both reach all three timers through their pick field
    dpt_channel #(
        .TMR_W(TMR_W),
        .DUTY_W(DUTY_W)
    ) u_chan_a (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(chan_a_enable_reg),
        .invert_i(chan_a_invert_reg),
        .pick_i(chan_a_timer_pick_reg),
        .duty_i(chan_a_duty_value),
        .tb2_i(period_timer_two_base_i),
        .rl2_i(period_timer_two_reload_i),
        .tb4_i(period_timer_four_base_i),
        .rl4_i(period_timer_four_reload_i),
        .tb6_i(period_timer_six_base_i),
        .rl6_i(period_timer_six_reload_i),
        .pin_o(chan_a_pin)
    );

    dpt_channel #(
        .TMR_W(TMR_W),
        .DUTY_W(DUTY_W)
    ) u_chan_b (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(chan_b_enable_reg),
        .invert_i(chan_b_invert_reg),
        .pick_i(chan_b_timer_pick_reg),
        .duty_i(chan_b_duty_value),
        .tb2_i(period_timer_two_base_i),
        .rl2_i(period_timer_two_reload_i),
        .tb4_i(period_timer_four_base_i),
        .rl4_i(period_timer_four_reload_i),
        .tb6_i(period_timer_six_base_i),
        .rl6_i(period_timer_six_reload_i),
        .pin_o(chan_b_pin)
    );

    assign chan_a_pin_o = chan_a_pin;
    assign chan_b_pin_o = chan_b_pin;

    // ========================================================
    // assertions
    sequence s_read_select;
        rd_i && (addr_i == dpt_pkg::OFS_TIMER_SOURCE_SELECT);
    endsequence

    sequence s_write_select;
        wr_i && (addr_i == dpt_pkg::OFS_TIMER_SOURCE_SELECT);
    endsequence

    AST_SELECT_UPPER_ZERO: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_read_select |=> rdata_o[7:4] == 4'h0)
        else $error("timer select upper bits not zero");

    AST_WRITE_PICK_B: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_write_select |=> chan_b_timer_pick_reg == $past(wdata_i[3:2]))
        else $error("channel b pick not written");

    AST_WRITE_PICK_A: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_write_select ##1 s_read_select
        |=> rdata_o[1:0] == $past(wdata_i[1:0], 2))
        else $error("channel a pick not read back");

    AST_RESET_PICK: assert property (
        @(posedge mclk_i)
        rst_i |=> chan_a_timer_pick_reg == dpt_pkg::PICK_T2 &&
                  chan_b_timer_pick_reg == dpt_pkg::PICK_T2)
        else $error("pick fields not at timer two after reset");

    AST_CONTROL_UNUSED: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && (addr_i == dpt_pkg::OFS_A_CONTROL ||
                 addr_i == dpt_pkg::OFS_B_CONTROL)
        |=> rdata_o[6] == 1'b0 && rdata_o[3:0] == 4'h0)
        else $error("unused control bits not zero");

    AST_DUTY_LOW_UNUSED: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && (addr_i == dpt_pkg::OFS_A_DUTY_LOW ||
                 addr_i == dpt_pkg::OFS_B_DUTY_LOW)
        |=> rdata_o[5:0] == 6'h00)
        else $error("unused duty low bits not zero");

    AST_READ_ONE_CYCLE: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == dpt_pkg::READ_ZERO)
        else $error("read data outside its cycle");

    // a duty byte written lands in the value handed to its channel
    AST_DUTY_A_HIGH: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == dpt_pkg::OFS_A_DUTY_HIGH
        |=> chan_a_duty_value[DUTY_W-1:dpt_pkg::SUB_W] == $past(wdata_i))
        else $error("channel a duty high byte not taken");

    AST_DUTY_A_LOW: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == dpt_pkg::OFS_A_DUTY_LOW
        |=> chan_a_duty_value[dpt_pkg::SUB_W-1:0] ==
            $past(wdata_i[dpt_pkg::DUTY_LOW_HI_BIT:dpt_pkg::DUTY_LOW_LO_BIT]))
        else $error("channel a duty low bits not taken");

    AST_DUTY_B_HIGH: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == dpt_pkg::OFS_B_DUTY_HIGH
        |=> chan_b_duty_value[DUTY_W-1:dpt_pkg::SUB_W] == $past(wdata_i))
        else $error("channel b duty high byte not taken");

    AST_DUTY_B_LOW: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == dpt_pkg::OFS_B_DUTY_LOW
        |=> chan_b_duty_value[dpt_pkg::SUB_W-1:0] ==
            $past(wdata_i[dpt_pkg::DUTY_LOW_HI_BIT:dpt_pkg::DUTY_LOW_LO_BIT]))
        else $error("channel b duty low bits not taken");

    // level readback shows the pin as driven, after polarity
    AST_LEVEL_A: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && addr_i == dpt_pkg::OFS_A_CONTROL
        |=> rdata_o[dpt_pkg::CTRL_LEVEL_BIT] == $past(chan_a_pin))
        else $error("channel a level readback wrong");

    AST_LEVEL_B: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        rd_i && addr_i == dpt_pkg::OFS_B_CONTROL
        |=> rdata_o[dpt_pkg::CTRL_LEVEL_BIT] == $past(chan_b_pin))
        else $error("channel b level readback wrong");
endmodule : dpt_dual_pwm
`default_nettype wire

// *** tb/dpt_tmr_model.sv ***
// period timer model feeding a ten-bit time base and reload pulse
`timescale 1ns/1ps
`default_nettype none
module dpt_tmr_model #(
    parameter int LIMIT = 3
) (
    input wire logic mclk_i,       // system clock
    input wire logic rst_i,        // sync reset, active high
    output logic [9:0] base_o,     // {count, sub-count} time base
    output logic reload_o          // high the cycle the count restarts
);
    // ========================================================
    // prescale of one: the two low bits step with the system clock
    localparam logic [9:0] TOP = 10'(4 * (LIMIT + 1) - 1);
    // wraps after count equals limit, so the period is 4*(limit+1)
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            base_o <= 10'h000;
        end else begin
            base_o <= (base_o == TOP) ? 10'h000 : base_o + 10'h001;
        end
    end
    // reload marks the first cycle of each period
    assign reload_o = (base_o == 10'h000);
endmodule : dpt_tmr_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the dual pwm block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module tb;
    // ========================================================
    // signals
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [9:0] b2, b4, b6;
    logic r2, r4, r6;
    logic chan_a_pin_o, chan_b_pin_o;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] rv;
    int hi, per;

    // ========================================================
    // clock, timers and device
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // distinct periods so a wrong timer pick shows as a wrong period
    dpt_tmr_model #(.LIMIT(3)) u_t2 (.mclk_i(mclk_i), .rst_i(rst_i),
        .base_o(b2), .reload_o(r2));
    dpt_tmr_model #(.LIMIT(5)) u_t4 (.mclk_i(mclk_i), .rst_i(rst_i),
        .base_o(b4), .reload_o(r4));
    dpt_tmr_model #(.LIMIT(7)) u_t6 (.mclk_i(mclk_i), .rst_i(rst_i),
        .base_o(b6), .reload_o(r6));
    dpt_dual_pwm dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .period_timer_two_base_i(b2), .period_timer_two_reload_i(r2), .period_timer_four_base_i(b4),
        .period_timer_four_reload_i(r4), .period_timer_six_base_i(b6), .period_timer_six_reload_i(r6),
        .chan_a_pin_o(chan_a_pin_o), .chan_b_pin_o(chan_b_pin_o));

    // ========================================================
    // verdict and hang guard
    task automatic give_verdict;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // ceiling well above the thousand or so cycles the tests need
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ========================================================
    // register bus and pin helpers
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    // data is taken only in the one cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // write then read back at the very next edge, no gap between strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask : wr_rd
    function automatic logic pin(input bit ch);
        return ch ? chan_b_pin_o : chan_a_pin_o;
    endfunction : pin
    task automatic wait_for(input bit ch, input logic v);
        int n;
        n = 0;
        while (pin(ch) !== v && n < 200) begin
            @(posedge mclk_i);
            #1 n++;
        end
        if (n == 200) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, pin(ch), v);
        end
    endtask : wait_for
    // active cycles of one period, then the whole period length
    task automatic count(input bit ch, input logic act, output int a,
                         output int p);
        a = 0;
        while (pin(ch) === act && a < 400) begin
            @(posedge mclk_i);
            #1 a++;
        end
        p = a;
        while (pin(ch) !== act && p < 400) begin
            @(posedge mclk_i);
            #1 p++;
        end
    endtask : count
    // skip the possibly partial first pulse after a change
    task automatic measure(input bit ch, input logic act, output int a,
                           output int p);
        wait_for(ch, act);
        wait_for(ch, ~act);
        wait_for(ch, act);
        count(ch, act, a, p);
    endtask : measure

    // ========================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h05, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), rv);
            `CHK(rv, exp[i])
        end
        `CHK({chan_a_pin_o, chan_b_pin_o}, 2'b00)
    endtask : t_reset

    // all ones into every register but the controls, which get 5F: disabled with invert set
    task automatic t_mask;
        logic [7:0] wv [7] = '{8'h5F, 8'hFF, 8'hFF, 8'h5F, 8'hFF, 8'hFF,
                               8'hFF};
        logic [7:0] ex [7] = '{8'h30, 8'hFF, 8'hC0, 8'h30, 8'hFF, 8'hC0,
                               8'h0F};
        for (int i = 0; i < 7; i++) begin
            wr(3'(i), wv[i]);
        end
        wr(3'h7, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(3'(i), rv);
            `CHK(rv, ex[i])
        end
        `CHK({chan_a_pin_o, chan_b_pin_o}, 2'b11)
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h00);
        @(posedge mclk_i);
        #1 `CHK({chan_a_pin_o, chan_b_pin_o}, 2'b00)
    endtask : t_mask

    // both channels on one timer code; b inverted, so its pulse is low
    task automatic t_pwm(input logic [1:0] code);
        wr_rd(3'h6, {4'hF, code, code}, rv);
        `CHK(rv, {4'h0, code, code})
        wr(3'h1, 8'h02);
        wr(3'h2, 8'h80);
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h80);
        wr(3'h0, 8'h80);
        wr(3'h3, 8'h90);
        measure(1'b0, 1'b1, hi, per);
        `CHK(hi, 10)
        `CHK(per, 8 + 8 * int'(code))
        measure(1'b1, 1'b0, hi, per);
        `CHK(hi, 6)
        `CHK(per, 8 + 8 * int'(code))
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h00);
    endtask : t_pwm

    // new duty written mid-pulse waits for the next rollover
    task automatic t_buffer;
        wr(3'h6, 8'h05);
        wr(3'h1, 8'h02);
        wr(3'h2, 8'h80);
        wr(3'h0, 8'h80);
        measure(1'b0, 1'b1, hi, per);
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
        wr(3'h1, 8'h01);
        // the write lands two edges into a ten-cycle pulse
        #1;
        count(1'b0, 1'b1, hi, per);
        `CHK(hi + 2, 10)
        wait_for(1'b0, 1'b1);
        count(1'b0, 1'b1, hi, per);
        `CHK(hi, 6)
        // count stops at the next rise, so the level bit reads high
        rd(3'h0, rv);
        `CHK(rv, 8'hA0)
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        repeat (40) @(posedge mclk_i);
        hi = 0;
        repeat (40) begin
            @(posedge mclk_i);
            #1 hi += int'(chan_a_pin_o === 1'b1);
        end
        `CHK(hi, 0)
        // reserved pick code: channel a holds its high level, no timer
        wr(3'h1, 8'h01);
        wait_for(1'b0, 1'b1);
        wr(3'h6, 8'h04);
        hi = 0;
        repeat (40) begin
            @(posedge mclk_i);
            #1 hi += int'(chan_a_pin_o === 1'b1);
        end
        `CHK(hi, 40)
        wr(3'h6, 8'h05);
        wr(3'h0, 8'h00);
    endtask : t_buffer

    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mask();
        for (int c = 1; c < 4; c++) begin
            t_pwm(2'(c));
        end
        t_buffer();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
